// ### inc/alu_core_pkg.sv
// constants, operation codes and request layout of the core execution unit
// assumes one clock edge per clock period and CLKS_PER_MC edges per machine cycle
package alu_core_pkg;

    // ------------------------------------------------------------
    // data memory map
    // ------------------------------------------------------------
    localparam int RAM_DEPTH = 192;
    localparam logic [7:0] RAM_TOP = 8'hBF;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam logic [7:0] INT_PRI_BIT_MASK = 8'h1F;
    localparam logic [7:0] INT_EN_BIT_MASK = 8'h9F;
    localparam logic [7:0] SFA_RESET = 8'h00;

    // ------------------------------------------------------------
    // special function area, one entry per register
    // ------------------------------------------------------------
    localparam int SFA_COUNT = 15;
    localparam int SI_PORT_ZERO = 0;
    localparam int SI_STACK = 1;
    localparam int SI_PTR_HIGH = 2;
    localparam int SI_PTR_LOW = 3;
    localparam int SI_TIMER_CTL = 4;
    localparam int SI_PORT_ONE = 5;
    localparam int SI_PORT_TWO = 6;
    localparam int SI_INT_EN = 7;
    localparam int SI_PORT_THREE = 8;
    localparam int SI_INT_PRI = 9;
    localparam int SI_SERIAL_STAT = 10;
    localparam int SI_STATUS_WORD = 11;
    localparam int SI_SEQ_NUM = 12;
    localparam int SI_PRIMARY = 13;
    localparam int SI_SECONDARY = 14;
    localparam logic [7:0] SFA_ADDR [SFA_COUNT] = '{
        8'h80, 8'h81, 8'h82, 8'h83, 8'h88, 8'h90, 8'hA0, 8'hA8,
        8'hB0, 8'hB8, 8'hC8, 8'hD0, 8'hD8, 8'hE0, 8'hF0};

    // ------------------------------------------------------------
    // status word fields and timing
    // ------------------------------------------------------------
    localparam int ST_CY = 7;
    localparam int ST_AC = 6;
    localparam int ST_BANK = 3;
    localparam int ST_OV = 2;
    localparam logic [3:0] CLKS_PER_MC = 4'h3;
    localparam logic [3:0] PH_PTR = 4'h0;
    localparam logic [3:0] PH_OPND = 4'h1;
    localparam logic [3:0] PH_EXEC = 4'h2;

    // ------------------------------------------------------------
    // operations and requests
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_ADD, OP_ADD_CARRY, OP_SUB_BORROW,
        OP_AND_A, OP_OR_A, OP_XOR_A,
        OP_AND_DA, OP_OR_DA, OP_XOR_DA,
        OP_AND_DI, OP_OR_DI, OP_XOR_DI,
        OP_INC, OP_DEC, OP_INC_DPP, OP_PRODUCT, OP_QUOTIENT,
        OP_ROT_L, OP_ROT_LC, OP_ROT_R, OP_ROT_RC,
        OP_SWAP, OP_CLEAR, OP_INVERT, OP_STORE,
        OP_BIT_CLR, OP_BIT_SET, OP_BIT_INV
    } alu_op_t;

    typedef enum logic [2:0] {
        MODE_PRI, MODE_REG, MODE_DIR, MODE_IND, MODE_IMM
    } src_mode_t;

    typedef struct packed {
        alu_op_t op;
        src_mode_t mode;
        logic [2:0] reg_sel;
        logic [7:0] dir_addr;
        logic [7:0] imm;
    } alu_req_t;

endpackage

// ### rtl/data_ram.sv
// internal data memory, one write and one registered read per clock
// assumes addresses above the top read as zero and are never written
`timescale 1ns/1ps
`default_nettype none
module data_ram
    import alu_core_pkg::*;
(
    input wire logic clock_in,
    input wire logic [7:0] rd_addr_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_addr_in,
    input wire logic [7:0] wr_data_in,
    output logic [7:0] rd_data_out
);
    logic [7:0] mem_r [RAM_DEPTH];

    always_ff @(posedge clock_in)
    begin
        if (wr_en_in && (wr_addr_in <= RAM_TOP))
            mem_r[wr_addr_in] <= wr_data_in;
        rd_data_out <= (rd_addr_in <= RAM_TOP) ? mem_r[rd_addr_in] : 8'h00;
    end
endmodule
`default_nettype wire

// ### rtl/alu_core.sv
// core execution unit: data memory addressing and arithmetic/logic ops
// assumes requests come from an instruction decoder in the clock domain
// Summary of operation
// - one-byte address, 192 RAM bytes 00h-BFh
// - special area on upper 128, direct only
// - overlapping RAM reached only by indirect
// - bit access; special bits at byte plus index
// - only multiples of eight; masked priority/enable bits
// - RAM bytes 20h-2Fh bit addressable, bits 00h-7Fh
// - add four source forms, one cycle
// - add with carry, same forms and timing
// - subtract with borrow, four forms, one cycle
// - and/or/xor into primary, one cycle
// - primary into direct byte, two bytes
// - immediate into direct byte, two cycles
// - rotate left/right, plain or through carry
// - swap nibbles, clear, complement, one cycle
// - direct add with carry, two bytes, one cycle
`timescale 1ns/1ps
`default_nettype none
module alu_core
    import alu_core_pkg::*;
(
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic req_valid_in,
    input wire alu_req_t req_in,
    output logic req_ready_out,
    output logic done_out,
    output logic [1:0] len_out,
    output logic [2:0] mcycles_out,
    output logic [7:0] pri_out,
    output logic [7:0] sec_out,
    output logic [7:0] status_word_out,
    output logic [15:0] data_ptr_out
);
    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} run_state_t;
    run_state_t state_r;
    alu_req_t req_r;
    logic [3:0] cnt_r, last_r, last_in;
    logic [2:0] mc_r, mc_in;
    logic [1:0] len_r, len_in;
    logic done_r, start, run, ph_ptr, ph_opnd, ph_exec, fin;
    logic di_in, da_in, bop_in, one_in;
    logic [7:0] sfa_r [SFA_COUNT];
    logic [7:0] sfa_nxt [SFA_COUNT];
    logic [7:0] pri, sec, stat;
    assign start = req_valid_in && (state_r == ST_IDLE);
    assign run = (state_r == ST_RUN);
    assign ph_ptr = run && (cnt_r == PH_PTR);
    assign ph_opnd = run && (cnt_r == PH_OPND);
    assign ph_exec = run && (cnt_r == PH_EXEC);
    assign fin = run && (cnt_r == last_r);
    assign di_in = req_in.op inside {OP_AND_DI, OP_OR_DI, OP_XOR_DI};
    assign da_in = req_in.op inside {OP_AND_DA, OP_OR_DA, OP_XOR_DA};
    assign bop_in = req_in.op inside {OP_BIT_CLR, OP_BIT_SET, OP_BIT_INV};
    assign one_in = req_in.op inside {OP_INC_DPP, OP_PRODUCT, OP_QUOTIENT,
        OP_ROT_L, OP_ROT_LC, OP_ROT_R, OP_ROT_RC, OP_SWAP, OP_CLEAR, OP_INVERT};
    assign mc_in = (req_in.op inside {OP_PRODUCT, OP_QUOTIENT}) ? 3'h4 :
        (di_in || req_in.op == OP_INC_DPP) ? 3'h2 : 3'h1;
    assign len_in = di_in ? 2'h3 : one_in ? 2'h1 : (da_in || bop_in) ? 2'h2 :
        (req_in.mode inside {MODE_DIR, MODE_IMM}) ? 2'h2 : 2'h1;
    assign last_in = 4'(({1'b0, mc_in} * CLKS_PER_MC) - 4'h1);
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_r <= ST_IDLE;
            req_r <= '0;
            cnt_r <= 4'h0;
            last_r <= 4'h0;
            mc_r <= 3'h0;
            len_r <= 2'h0;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= fin;
            cnt_r <= start ? 4'h0 : 4'(cnt_r + 4'h1);
            if (start)
            begin
                state_r <= ST_RUN;
                req_r <= req_in;
                last_r <= last_in;
                mc_r <= mc_in;
                len_r <= len_in;
            end
            else if (fin)
                state_r <= ST_IDLE;
        end
    end
    // ------------------------------------------------------------
    // address resolution
    // ------------------------------------------------------------
    logic bop, use_dir, sfa_r_t, hit_any, bit_ok, tgt_ok, ram_we, mem_wr;
    logic [7:0] ram_q, bank_addr, ptr_addr, bit_byte, res_addr, addr_r, bmask, sfa_q, mem_v;
    logic [SFA_COUNT-1:0] hit;
    logic [2:0] bidx;
    assign bop = req_r.op inside {OP_BIT_CLR, OP_BIT_SET, OP_BIT_INV};
    assign use_dir = (req_r.mode == MODE_DIR) || bop ||
        (req_r.op inside {OP_AND_DA, OP_OR_DA, OP_XOR_DA, OP_AND_DI, OP_OR_DI, OP_XOR_DI});
    assign bidx = req_r.dir_addr[2:0];
    assign bank_addr = {3'b000, stat[4:ST_BANK], req_r.reg_sel};
    assign ptr_addr = {3'b000, stat[4:ST_BANK], 2'b00, req_r.reg_sel[0]};
    assign bit_byte = req_r.dir_addr[7] ? {req_r.dir_addr[7:3], 3'b000} :
        8'(BIT_RAM_BASE + {4'h0, req_r.dir_addr[6:3]});
    assign res_addr = bop ? bit_byte : (req_r.mode == MODE_REG) ? bank_addr :
        (use_dir ? req_r.dir_addr : ram_q);
    // the direct high half goes to the special area, indirect stays in RAM
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            addr_r <= 8'h00;
            sfa_r_t <= 1'b0;
        end
        else if (ph_opnd)
        begin
            addr_r <= res_addr;
            sfa_r_t <= use_dir && res_addr[7];
        end
    end
    for (genvar g = 0; g < SFA_COUNT; g++)
    begin : g_hit
        assign hit[g] = (addr_r == SFA_ADDR[g]);
    end
    assign hit_any = |hit;
    assign bmask = hit[SI_INT_PRI] ? INT_PRI_BIT_MASK :
        hit[SI_INT_EN] ? INT_EN_BIT_MASK : 8'hFF;
    assign bit_ok = !bop || !sfa_r_t || (addr_r[2:0] == 3'b000 && bmask[bidx]);
    assign tgt_ok = (sfa_r_t ? hit_any : (addr_r <= RAM_TOP)) && bit_ok;
    always_comb
    begin
        sfa_q = 8'h00;
        for (int i = 0; i < SFA_COUNT; i++)
            sfa_q = sfa_q | ({8{hit[i]}} & sfa_r[i]);
    end
    data_ram u_ram (
        .clock_in(clock_in),
        .rd_addr_in(ph_ptr ? ptr_addr : res_addr),
        .wr_en_in(ram_we),
        .wr_addr_in(addr_r),
        .wr_data_in(mem_v),
        .rd_data_out(ram_q)
    );
    // ------------------------------------------------------------
    // arithmetic and logic
    // ------------------------------------------------------------
    logic [7:0] opnd, lg_y, lg_v, pri_v, sec_v, bit_m;
    logic [8:0] add9, sub9;
    logic [4:0] add5, sub5;
    logic [15:0] prod, dpp;
    logic cin, cy, pri_we, sec_we, cy_we, cy_v, ac_we, ac_v, ov_we, ov_v, mem_we, dpp_we;
    assign pri = sfa_r[SI_PRIMARY];
    assign sec = sfa_r[SI_SECONDARY];
    assign stat = sfa_r[SI_STATUS_WORD];
    assign cy = stat[ST_CY];
    assign dpp = {sfa_r[SI_PTR_HIGH], sfa_r[SI_PTR_LOW]};
    assign opnd = (req_r.mode == MODE_IMM && !use_dir) ? req_r.imm :
        (req_r.mode == MODE_PRI && !use_dir) ? pri :
        !tgt_ok ? 8'h00 : sfa_r_t ? sfa_q : ram_q;
    assign cin = (req_r.op == OP_ADD_CARRY) && cy;
    assign add9 = 9'({1'b0, pri} + {1'b0, opnd} + {8'h00, cin});
    assign add5 = 5'({1'b0, pri[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin});
    assign sub9 = 9'({1'b0, pri} - {1'b0, opnd} - {8'h00, cy});
    assign sub5 = 5'({1'b0, pri[3:0]} - {1'b0, opnd[3:0]} - {4'h0, cy});
    assign lg_y = (req_r.op inside {OP_AND_DI, OP_OR_DI, OP_XOR_DI}) ? req_r.imm : pri;
    assign lg_v = (req_r.op inside {OP_AND_A, OP_AND_DA, OP_AND_DI}) ? (opnd & lg_y) :
        (req_r.op inside {OP_OR_A, OP_OR_DA, OP_OR_DI}) ? (opnd | lg_y) : (opnd ^ lg_y);
    assign prod = 16'(pri * sec);
    assign bit_m = 8'(8'h01 << bidx);
    always_comb
    begin
        {pri_we, sec_we, cy_we, ac_we, ac_v, ov_we, ov_v, mem_we, dpp_we} = 9'h000;
        pri_v = pri;
        sec_v = sec;
        cy_v = cy;
        mem_v = opnd;
        unique case (req_r.op)
            OP_ADD, OP_ADD_CARRY:
            begin
                {pri_we, pri_v, cy_we, cy_v} = {1'b1, add9[7:0], 1'b1, add9[8]};
                {ac_we, ac_v, ov_we} = {1'b1, add5[4], 1'b1};
                ov_v = (pri[7] == opnd[7]) && (add9[7] != pri[7]);
            end
            OP_SUB_BORROW:
            begin
                {pri_we, pri_v, cy_we, cy_v} = {1'b1, sub9[7:0], 1'b1, sub9[8]};
                {ac_we, ac_v, ov_we} = {1'b1, sub5[4], 1'b1};
                ov_v = (pri[7] != opnd[7]) && (sub9[7] != pri[7]);
            end
            OP_AND_A, OP_OR_A, OP_XOR_A: {pri_we, pri_v} = {1'b1, lg_v};
            OP_AND_DA, OP_OR_DA, OP_XOR_DA: {mem_we, mem_v} = {1'b1, lg_v};
            OP_AND_DI, OP_OR_DI, OP_XOR_DI: {mem_we, mem_v} = {1'b1, lg_v};
            OP_INC, OP_DEC:
            begin
                mem_v = (req_r.op == OP_INC) ? 8'(opnd + 8'h01) : 8'(opnd - 8'h01);
                pri_we = (req_r.mode == MODE_PRI);
                pri_v = mem_v;
                mem_we = (req_r.mode != MODE_PRI) && (req_r.mode != MODE_IMM);
            end
            OP_INC_DPP: dpp_we = 1'b1;
            OP_PRODUCT:
            begin
                {pri_we, pri_v, sec_we, sec_v} = {1'b1, prod[7:0], 1'b1, prod[15:8]};
                {cy_we, cy_v, ov_we, ov_v} = {1'b1, 1'b0, 1'b1, (prod[15:8] != 8'h00)};
            end
            OP_QUOTIENT:
            begin
                {cy_we, cy_v, ov_we, ov_v} = {1'b1, 1'b0, 1'b1, (sec == 8'h00)};
                {pri_we, sec_we} = {2{sec != 8'h00}};
                pri_v = (sec != 8'h00) ? (pri / sec) : pri;
                sec_v = (sec != 8'h00) ? (pri % sec) : sec;
            end
            OP_ROT_L: {pri_we, pri_v} = {1'b1, pri[6:0], pri[7]};
            OP_ROT_LC: {pri_we, pri_v, cy_we, cy_v} = {1'b1, pri[6:0], cy, 1'b1, pri[7]};
            OP_ROT_R: {pri_we, pri_v} = {1'b1, pri[0], pri[7:1]};
            OP_ROT_RC: {pri_we, pri_v, cy_we, cy_v} = {1'b1, cy, pri[7:1], 1'b1, pri[0]};
            OP_SWAP: {pri_we, pri_v} = {1'b1, pri[3:0], pri[7:4]};
            OP_CLEAR: {pri_we, pri_v} = {1'b1, 8'h00};
            OP_INVERT: {pri_we, pri_v} = {1'b1, ~pri};
            OP_STORE: {mem_we, mem_v} = {(req_r.mode inside {MODE_REG, MODE_DIR, MODE_IND}), pri};
            OP_BIT_CLR: {mem_we, mem_v} = {1'b1, opnd & ~bit_m};
            OP_BIT_SET: {mem_we, mem_v} = {1'b1, opnd | bit_m};
            OP_BIT_INV: {mem_we, mem_v} = {1'b1, opnd ^ bit_m};
            default: mem_we = 1'b0;
        endcase
    end
    // ------------------------------------------------------------
    // write back
    // ------------------------------------------------------------
    assign mem_wr = ph_exec && mem_we && tgt_ok;
    assign ram_we = mem_wr && !sfa_r_t;
    always_comb
    begin
        for (int i = 0; i < SFA_COUNT; i++)
            sfa_nxt[i] = (mem_wr && sfa_r_t && hit[i]) ? mem_v : sfa_r[i];
        if (ph_exec && pri_we) sfa_nxt[SI_PRIMARY] = pri_v;
        if (ph_exec && sec_we) sfa_nxt[SI_SECONDARY] = sec_v;
        if (ph_exec && cy_we) sfa_nxt[SI_STATUS_WORD][ST_CY] = cy_v;
        if (ph_exec && ac_we) sfa_nxt[SI_STATUS_WORD][ST_AC] = ac_v;
        if (ph_exec && ov_we) sfa_nxt[SI_STATUS_WORD][ST_OV] = ov_v;
        if (ph_exec && dpp_we)
            {sfa_nxt[SI_PTR_HIGH], sfa_nxt[SI_PTR_LOW]} = 16'(dpp + 16'h0001);
    end
    always_ff @(posedge clock_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            sfa_r <= '{default: SFA_RESET};
        else
            sfa_r <= sfa_nxt;
    end
    assign req_ready_out = (state_r == ST_IDLE);
    assign done_out = done_r;
    assign len_out = len_r;
    assign mcycles_out = mc_r;
    assign pri_out = pri;
    assign sec_out = sec;
    assign status_word_out = {stat[7:1], ^pri};
    assign data_ptr_out = dpp;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    property p_ind_top;
        ph_exec && req_r.mode == MODE_IND && addr_r > RAM_TOP |-> !ram_we && !mem_wr;
    endproperty
    a_ind_top: assert property (p_ind_top) else $error("write above top");
    property p_dir_high;
        ph_exec && req_r.op == OP_STORE && req_r.mode == MODE_DIR && req_r.dir_addr[7] |-> !ram_we;
    endproperty
    a_dir_high: assert property (p_dir_high) else $error("direct high hit RAM");
    property p_ind_overlap;
        ph_exec && req_r.op == OP_STORE && req_r.mode == MODE_IND && addr_r[7] && addr_r <= RAM_TOP
        |-> ram_we && !sfa_r_t;
    endproperty
    a_ind_overlap: assert property (p_ind_overlap) else $error("indirect missed RAM");
    property p_bit_sfa;
        ph_exec && bop && req_r.dir_addr[7] |-> sfa_r_t && addr_r == {req_r.dir_addr[7:3], 3'b000};
    endproperty
    a_bit_sfa: assert property (p_bit_sfa) else $error("bad special bit byte");
    property p_bit_pri_mask;
        ph_exec && bop && hit[SI_INT_PRI] && bidx > 3'h4 |-> !mem_wr;
    endproperty
    a_bit_pri_mask: assert property (p_bit_pri_mask) else $error("masked bit written");
    property p_bit_ram;
        ph_exec && bop && !req_r.dir_addr[7] |-> !sfa_r_t && addr_r == 8'(8'h20 + req_r.dir_addr[6:3]);
    endproperty
    a_bit_ram: assert property (p_bit_ram) else $error("bad RAM bit byte");
    property p_add_imm;
        start && req_in.op == OP_ADD && req_in.mode == MODE_IMM
        |-> ##4 done_out && len_out == 2'h2 && pri_out == 8'($past(pri_out, 4) + $past(req_in.imm, 4));
    endproperty
    a_add_imm: assert property (p_add_imm) else $error("add result or timing");
    property p_add_with_carry_dir;
        start && req_in.op == OP_ADD_CARRY && req_in.mode == MODE_DIR |-> ##3 !done_out ##1 done_out && len_out == 2'h2;
    endproperty
    a_add_with_carry_dir: assert property (p_add_with_carry_dir) else $error("carry add timing");
    property p_sub_reg;
        start && req_in.op == OP_SUB_BORROW && req_in.mode == MODE_REG |-> ##4 done_out && len_out == 2'h1;
    endproperty
    a_sub_reg: assert property (p_sub_reg) else $error("subtract timing");
    property p_logic_di;
        start && req_in.op == OP_XOR_DI |-> ##4 !done_out ##3 done_out && len_out == 2'h3;
    endproperty
    a_logic_di: assert property (p_logic_di) else $error("immediate to direct timing");
    property p_swap;
        start && req_in.op == OP_SWAP |-> ##4 pri_out == {$past(pri_out[3:0], 4), $past(pri_out[7:4], 4)};
    endproperty
    a_swap: assert property (p_swap) else $error("swap result");
    property p_rot_lc;
        start && req_in.op == OP_ROT_LC |-> ##4 status_word_out[ST_CY] == $past(pri_out[7], 4);
    endproperty
    a_rot_lc: assert property (p_rot_lc) else $error("rotate carry");
    property p_product;
        start && req_in.op == OP_PRODUCT
        |-> ##13 done_out && {sec_out, pri_out} == 16'($past(pri_out, 13) * $past(sec_out, 13));
    endproperty
    a_product: assert property (p_product) else $error("multiply result or timing");
    property p_inc_dpp;
        start && req_in.op == OP_INC_DPP |-> ##7 done_out && data_ptr_out == 16'($past(data_ptr_out, 7) + 16'h0001);
    endproperty
    a_inc_dpp: assert property (p_inc_dpp) else $error("pointer increment");
    c_add: cover property (start && req_in.op == OP_ADD_CARRY);
    c_bit: cover property (mem_wr && bop && sfa_r_t);
    c_div0: cover property (ph_exec && req_r.op == OP_QUOTIENT && sec == 8'h00);
endmodule
`default_nettype wire

// ### verif/tb_alu_core.sv
// self-checking bench for the core execution unit
// assumes the package and the unit compile first; drives requests one at a time
`timescale 1ns/1ps
`default_nettype none
module tb_alu_core
    import alu_core_pkg::*;
;
    // ------------------------------------------------------------
    // signals and table
    // ------------------------------------------------------------
    typedef struct {
        alu_op_t op;
        src_mode_t md;
        logic [7:0] v;
        logic [7:0] pri;
        logic cy;
        logic [4:0] lm;
    } row_t;
    logic clock_in;
    logic arst_n_in;
    logic req_valid_in;
    alu_req_t req_in;
    logic req_ready_out;
    logic done_out;
    logic [1:0] len_out;
    logic [2:0] mcycles_out;
    logic [7:0] pri_out;
    logic [7:0] sec_out;
    logic [7:0] status_word_out;
    logic [15:0] data_ptr_out;
    int n_mismatch = 0;
    int tests_run = 0;
    int lat;
    int lat1;
    // lm is {length, machine cycles}; zero skips that check
    row_t rows [55] = '{
    '{OP_CLEAR,MODE_PRI,8'h00,8'h00,1'b0,5'h09}, '{OP_STORE,MODE_DIR,8'h20,8'h00,1'b0,5'h00},
    '{OP_STORE,MODE_DIR,8'h2F,8'h00,1'b0,5'h00}, '{OP_ADD,MODE_IMM,8'h35,8'h35,1'b0,5'h11},
    '{OP_STORE,MODE_DIR,8'h40,8'h35,1'b0,5'h00}, '{OP_STORE,MODE_REG,8'h03,8'h35,1'b0,5'h00},
    '{OP_CLEAR,MODE_PRI,8'h00,8'h00,1'b0,5'h09}, '{OP_ADD,MODE_DIR,8'h40,8'h35,1'b0,5'h11},
    '{OP_ADD,MODE_REG,8'h03,8'h6A,1'b0,5'h09}, '{OP_ADD,MODE_IMM,8'hE0,8'h4A,1'b1,5'h11},
    '{OP_ADD_CARRY,MODE_IMM,8'h01,8'h4C,1'b0,5'h11},
    '{OP_ADD_CARRY,MODE_IMM,8'hC0,8'h0C,1'b1,5'h11},
    '{OP_ADD_CARRY,MODE_DIR,8'h40,8'h42,1'b0,5'h11},
    '{OP_SUB_BORROW,MODE_IMM,8'h50,8'hF2,1'b1,5'h11},
    '{OP_SUB_BORROW,MODE_REG,8'h03,8'hBC,1'b0,5'h09},
    '{OP_AND_A,MODE_IMM,8'h0F,8'h0C,1'b0,5'h11}, '{OP_OR_A,MODE_DIR,8'h40,8'h3D,1'b0,5'h11},
    '{OP_XOR_A,MODE_REG,8'h03,8'h08,1'b0,5'h09}, '{OP_SWAP,MODE_PRI,8'h00,8'h80,1'b0,5'h09},
    '{OP_INVERT,MODE_PRI,8'h00,8'h7F,1'b0,5'h09}, '{OP_ROT_LC,MODE_PRI,8'h00,8'hFE,1'b0,5'h09},
    '{OP_ROT_LC,MODE_PRI,8'h00,8'hFC,1'b1,5'h09}, '{OP_ROT_RC,MODE_PRI,8'h00,8'hFE,1'b0,5'h09},
    '{OP_ROT_R,MODE_PRI,8'h00,8'h7F,1'b0,5'h09}, '{OP_ROT_L,MODE_PRI,8'h00,8'hFE,1'b0,5'h09},
    '{OP_INC,MODE_PRI,8'h00,8'hFF,1'b0,5'h09}, '{OP_DEC,MODE_PRI,8'h00,8'hFE,1'b0,5'h09},
    '{OP_XOR_DA,MODE_DIR,8'h40,8'hFE,1'b0,5'h11}, '{OP_INC,MODE_DIR,8'h40,8'hFE,1'b0,5'h11},
    '{OP_CLEAR,MODE_PRI,8'h00,8'h00,1'b0,5'h09}, '{OP_ADD,MODE_DIR,8'h40,8'hCC,1'b0,5'h11},
    '{OP_ADD,MODE_IMM,8'hC4,8'h90,1'b1,5'h11}, '{OP_STORE,MODE_REG,8'h00,8'h90,1'b1,5'h00},
    '{OP_SWAP,MODE_PRI,8'h00,8'h09,1'b1,5'h09}, '{OP_STORE,MODE_IND,8'h00,8'h09,1'b1,5'h00},
    '{OP_CLEAR,MODE_PRI,8'h00,8'h00,1'b1,5'h09}, '{OP_ADD,MODE_DIR,8'h90,8'h00,1'b0,5'h11},
    '{OP_ADD,MODE_IND,8'h00,8'h09,1'b0,5'h09}, '{OP_BIT_SET,MODE_DIR,8'h07,8'h09,1'b0,5'h00},
    '{OP_BIT_SET,MODE_DIR,8'h7F,8'h09,1'b0,5'h00}, '{OP_BIT_SET,MODE_DIR,8'hBD,8'h09,1'b0,5'h00},
    '{OP_BIT_SET,MODE_DIR,8'hAE,8'h09,1'b0,5'h00}, '{OP_BIT_SET,MODE_DIR,8'hAF,8'h09,1'b0,5'h00},
    '{OP_BIT_INV,MODE_DIR,8'hE1,8'h0B,1'b0,5'h00}, '{OP_CLEAR,MODE_PRI,8'h00,8'h00,1'b0,5'h09},
    '{OP_ADD,MODE_DIR,8'h20,8'h80,1'b0,5'h11}, '{OP_ADD,MODE_DIR,8'h2F,8'h00,1'b1,5'h11},
    '{OP_ADD,MODE_DIR,8'hB8,8'h00,1'b0,5'h11}, '{OP_ADD,MODE_DIR,8'hA8,8'h80,1'b0,5'h11},
    '{OP_BIT_CLR,MODE_DIR,8'hE7,8'h00,1'b0,5'h00}, '{OP_ADD,MODE_IMM,8'hC5,8'hC5,1'b0,5'h11},
    '{OP_STORE,MODE_REG,8'h01,8'hC5,1'b0,5'h00}, '{OP_STORE,MODE_IND,8'h01,8'hC5,1'b0,5'h00},
    '{OP_CLEAR,MODE_PRI,8'h00,8'h00,1'b0,5'h09}, '{OP_ADD,MODE_IND,8'h01,8'h00,1'b0,5'h09}};

    alu_core u_alu_core (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .req_valid_in(req_valid_in),
        .req_in(req_in),
        .req_ready_out(req_ready_out),
        .done_out(done_out),
        .len_out(len_out),
        .mcycles_out(mcycles_out),
        .pri_out(pri_out),
        .sec_out(sec_out),
        .status_word_out(status_word_out),
        .data_ptr_out(data_ptr_out)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic run(input alu_op_t op, input src_mode_t md, input logic [7:0] v);
        req_in = '{op, md, v[2:0], v, v};
        req_valid_in = 1'b1;
        @(posedge clock_in);
        #1;
        req_valid_in = 1'b0;
        lat = 0;
        while (done_out !== 1'b1 && lat < 40)
        begin
            @(posedge clock_in);
            #1;
            lat++;
        end
        if (lat == 40)
            chk(16'h0001, 16'h0000);
    endtask

    task automatic rst_chk;
        chk({sec_out, pri_out}, 16'h0000);
        chk({status_word_out, 8'h00}, 16'h0000);
        chk(data_ptr_out, 16'h0000);
        chk({9'h000, req_ready_out, done_out, len_out, mcycles_out}, 16'h0040);
    endtask

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and tests
    // ------------------------------------------------------------
    initial
    begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    initial
    begin
        repeat (5000) @(posedge clock_in);
        n_mismatch++;
        $display("watchdog expired");
        summarize();
    end

    initial
    begin
        arst_n_in = 1'b0;
        req_valid_in = 1'b0;
        req_in = '0;
        repeat (6) @(posedge clock_in);
        #1;
        rst_chk();
        arst_n_in = 1'b1;
        $display("reset test done");
        foreach (rows[i])
        begin
            run(rows[i].op, rows[i].md, rows[i].v);
            chk({7'h00, status_word_out[ST_CY], pri_out}, {7'h00, rows[i].cy, rows[i].pri});
            chk({15'h0000, status_word_out[0]}, {15'h0000, ^rows[i].pri});
            if (rows[i].lm != 5'h00)
                chk({11'h000, len_out, mcycles_out}, {11'h000, rows[i].lm});
        end
        $display("table test done");
        run(OP_XOR_DI, MODE_DIR, 8'h40);
        lat1 = lat;
        chk({11'h000, len_out, mcycles_out}, 16'h001A);
        run(OP_ADD, MODE_DIR, 8'h40);
        chk({8'h00, pri_out}, 16'h008C);
        chk(16'(lat1 - lat), 16'h0003);
        $display("immediate into direct test done");
        run(OP_CLEAR, MODE_PRI, 8'h00);
        run(OP_ADD, MODE_IMM, 8'h12);
        run(OP_STORE, MODE_DIR, 8'hF0);
        chk({8'h00, sec_out}, 16'h0012);
        run(OP_ADD, MODE_IMM, 8'h22);
        lat1 = lat;
        run(OP_PRODUCT, MODE_PRI, 8'h00);
        chk({sec_out, pri_out}, 16'h03A8);
        chk({11'h000, len_out, mcycles_out}, 16'h000C);
        chk(16'(lat - lat1), 16'h0009);
        chk({8'h00, status_word_out & 8'hC4}, 16'h0004);
        run(OP_INC, MODE_PRI, 8'h00);
        run(OP_QUOTIENT, MODE_PRI, 8'h00);
        chk({sec_out, pri_out}, 16'h0138);
        $display("product and quotient test done");
        run(OP_CLEAR, MODE_PRI, 8'h00);
        run(OP_INVERT, MODE_PRI, 8'h00);
        run(OP_STORE, MODE_DIR, 8'h83);
        chk(data_ptr_out, 16'h00FF);
        run(OP_INC_DPP, MODE_PRI, 8'h00);
        chk(data_ptr_out, 16'h0100);
        chk({11'h000, len_out, mcycles_out}, 16'h000A);
        $display("pointer pair test done");
        req_in = '{OP_ADD, MODE_IMM, 3'h0, 8'h00, 8'h11};
        req_valid_in = 1'b1;
        @(posedge clock_in);
        #1;
        req_valid_in = 1'b0;
        arst_n_in = 1'b0;
        #1;
        rst_chk();
        @(posedge clock_in);
        #1;
        arst_n_in = 1'b1;
        run(OP_ADD, MODE_IMM, 8'h11);
        chk({8'h00, pri_out}, 16'h0011);
        $display("mid-run reset test done");
        summarize();
    end
endmodule
`default_nettype wire
